//--- dv/uarb_rx_monitor.sv
// Port-level assertions for the autobaud serial receiver.
`timescale 1ns/100ps
module uarb_rx_monitor (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        multi_buffer,
	input wire logic        rx_buffer_full_irq_enable,
	input wire logic        idle_irq_enable,
	input wire logic        error_irq_enable,
	input wire logic        data_read,
	input wire logic        full_flag_clear,
	input wire logic        baud_divider_wr,
	input wire logic [15:0] baud_divider_wdata,
	input wire logic        autobaud_done_clear,
	input wire logic [8:0]  rx_data,
	input wire logic        rx_buffer_full_flag,
	input wire logic        overrun_flag,
	input wire logic        noise_flag,
	input wire logic        autobaud_done_flag,
	input wire logic        autobaud_error_flag,
	input wire logic [15:0] baud_divider,
	input wire logic        dma_valid,
	input wire logic        irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_full_irq: assert property (rx_buffer_full_flag && rx_buffer_full_irq_enable |=> irq)
		else $error("full flag with enable gave no interrupt");
	a_single_clear: assert property (!multi_buffer && $fell(rx_buffer_full_flag) |->
		$past(data_read) || $past(full_flag_clear))
		else $error("full flag dropped without a read or clear");
	a_multi_push: assert property (multi_buffer && rx_buffer_full_flag |=> dma_valid)
		else $error("buffered word did not reach the dma side");
	a_overrun_keep: assert property ($rose(overrun_flag) |-> $stable(rx_data))
		else $error("receive buffer changed on overrun");
	a_overrun_irq: assert property (overrun_flag &&
		(rx_buffer_full_irq_enable || error_irq_enable) |=> irq)
		else $error("overrun gave no interrupt");
	a_noise_full: assert property ($rose(noise_flag) |-> $rose(rx_buffer_full_flag))
		else $error("noise flag rose apart from full flag");
	a_quiet_single: assert property (!multi_buffer && !rx_buffer_full_irq_enable &&
		!idle_irq_enable && !overrun_flag |=> !irq)
		else $error("interrupt in single mode without a cause");
	a_div_load: assert property (baud_divider_wr |=>
		baud_divider == $past(baud_divider_wdata))
		else $error("divider write not taken");
	a_done_clear: assert property (autobaud_done_clear |=>
		!autobaud_done_flag && !autobaud_error_flag)
		else $error("autobaud flags survived a clear");
	c_overrun: cover property ($rose(overrun_flag));
	c_done: cover property ($rose(autobaud_done_flag));
	c_fifo_held: cover property (multi_buffer && dma_valid && rx_buffer_full_flag);
endmodule

bind uarb_rx uarb_rx_monitor mon (.*);

//--- dv/uarb_tx_model.sv
// Behavioural remote transmitter that drives the receive line.
`timescale 1ns/100ps
module uarb_tx_model (
	input wire logic clk,
	output logic     line
);
	// The line idles high between frames, as a pulled-up serial line does.
	initial line = 1'b1;

	// Start bit, n data bits, then a stop bit of level stp; nz adds a one-clock
	// glitch at the centre of data bit 3 so that the samples disagree.
	task automatic send(input logic [8:0] d, input int n, input int bt,
		input logic stp, input bit nz);
		for (int i = 0; i < n + 2; i++) begin
			line = (i == 0) ? 1'b0 : (i > n) ? stp : d[i-1];
			for (int c = 0; c < bt; c++) begin
				@(negedge clk);
				if (nz && i == 4 && (c == bt / 2 - 1 || c == bt / 2))
					line = ~line;
			end
		end
		line = 1'b1;
	endtask
endmodule

//--- dv/uart_receiver_autobaud_tb.sv
// Self-checking testbench for the autobaud serial receiver.
`timescale 1ns/100ps
module uart_receiver_autobaud_tb;
	logic        clk, reset_n, rx_in, port_enable, receiver_enable, oversample_select;
	logic [1:0]  word_length_select, autobaud_pattern_select;
	logic        parity_enable, parity_odd, multi_buffer, rx_buffer_full_irq_enable;
	logic        idle_irq_enable, error_irq_enable, status_read, data_read, full_flag_clear;
	logic        idle_clear, baud_divider_wr, autobaud_enable, autobaud_done_clear, dma_ready;
	logic [15:0] baud_divider_wdata, baud_divider;
	logic        dma_valid, rx_buffer_full_flag, overrun_flag, noise_flag, framing_error_flag;
	logic        parity_error_flag, idle_flag, autobaud_done_flag, autobaud_error_flag, irq;
	logic [8:0]  dma_data, rx_data;
	int          miscompares, checks;

	uarb_tx_model tx (.clk(clk), .line(rx_in));
	uarb_rx uut (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_up(input bit ok);
		if (!ok) begin
			miscompares++;
			$display("[ERR] %0t wait ran out", $time);
			end_of_test();
		end
	endtask

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask

	task automatic clr();
		pulse(status_read);
		pulse(data_read);
	endtask

	task automatic set_div(input logic [15:0] v);
		@(negedge clk);
		baud_divider_wdata = v;
		baud_divider_wr = 1'b1;
		@(negedge clk);
		baud_divider_wr = 1'b0;
		chk(baud_divider, v);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_basic();
		chk({rx_data, rx_buffer_full_flag, overrun_flag, irq, dma_valid}, 20'h0);
		chk(baud_divider, 16'h0010);
		set_div(16'h0020);
		rx_buffer_full_irq_enable = 1'b1;
		tx.send(9'h0a5, 8, 32, 1'b1, 1'b0);
		chk({rx_data, rx_buffer_full_flag}, {9'h0a5, 1'b1});
		@(negedge clk);
		chk(irq, 1'b1);
		pulse(data_read);
		chk(rx_buffer_full_flag, 1'b0);
		tx.send(9'h05a, 8, 32, 1'b1, 1'b0);
		pulse(full_flag_clear);
		chk({rx_data, rx_buffer_full_flag}, {9'h05a, 1'b0});
		rx_buffer_full_irq_enable = 1'b0;
	endtask

	task automatic t_len();
		logic [8:0] d [3] = '{9'h03c, 9'h1c3, 9'h05a};
		int         n [3] = '{8, 9, 7};
		for (int i = 0; i < 3; i++) begin
			word_length_select = 2'(i);
			oversample_select = (i != 1);
			tx.send(d[i], n[i], 32, 1'b1, 1'b0);
			chk(rx_data, d[i]);
			pulse(data_read);
		end
		word_length_select = 2'b00;
		oversample_select = 1'b0;
	endtask

	task automatic t_parity();
		parity_enable = 1'b1;
		for (int i = 0; i < 2; i++) begin
			parity_odd = i[0];
			tx.send(9'h031, 8, 32, 1'b1, 1'b0);
			chk({rx_data, parity_error_flag}, {9'h031, ~i[0]});
			clr();
			chk(parity_error_flag, 1'b0);
		end
		parity_enable = 1'b0;
	endtask

	task automatic t_errors();
		error_irq_enable = 1'b1;
		tx.send(9'h000, 8, 32, 1'b0, 1'b0);
		chk({rx_data, framing_error_flag, rx_buffer_full_flag}, {9'h000, 2'b11});
		chk(irq, 1'b0);
		clr();
		tx.send(9'h0a5, 8, 32, 1'b1, 1'b1);
		chk({rx_data, noise_flag, rx_buffer_full_flag}, {9'h0a5, 2'b11});
		chk(irq, 1'b0);
		clr();
		tx.send(9'h011, 8, 32, 1'b1, 1'b0);
		tx.send(9'h022, 8, 32, 1'b1, 1'b0);
		chk({rx_data, overrun_flag, rx_buffer_full_flag}, {9'h011, 2'b11});
		chk(irq, 1'b1);
		pulse(data_read);
		chk({overrun_flag, rx_buffer_full_flag}, 2'b10);
		clr();
		chk(overrun_flag, 1'b0);
		error_irq_enable = 1'b0;
		idle_irq_enable = 1'b1;
		for (int k = 0; k < 400 && idle_flag !== 1'b1; k++)
			@(negedge clk);
		give_up(idle_flag === 1'b1);
		@(negedge clk);
		chk(irq, 1'b1);
		pulse(idle_clear);
		idle_irq_enable = 1'b0;
		chk(idle_flag, 1'b0);
	endtask

	task automatic t_multi();
		multi_buffer = 1'b1;
		for (int i = 0; i < 5; i++)
			tx.send(9'h040 + 9'(i), 8, 32, 1'b1, 1'b0);
		chk({dma_valid, rx_buffer_full_flag}, 2'b11);
		pulse(data_read);
		chk(rx_buffer_full_flag, 1'b1);
		for (int i = 0; i < 5; i++) begin
			for (int k = 0; k < 8 && dma_valid !== 1'b1; k++)
				@(negedge clk);
			give_up(dma_valid === 1'b1);
			chk(dma_data, 9'h040 + 9'(i));
			dma_ready = 1'b1;
			@(negedge clk);
			dma_ready = 1'b0;
		end
		chk({dma_valid, rx_buffer_full_flag}, 2'b00);
		error_irq_enable = 1'b1;
		tx.send(9'h000, 8, 32, 1'b0, 1'b0);
		chk({framing_error_flag, irq}, 2'b11);
		clr();
		dma_ready = 1'b1;
		repeat (2) @(negedge clk);
		{multi_buffer, error_irq_enable, dma_ready} = 3'b000;
	endtask

	// Patterns carry no falling edge after the measured one, so no stray frame follows.
	task automatic t_auto();
		logic [8:0] d [4] = '{9'h0ff, 9'h0fe, 9'h07f, 9'h055};
		logic [2:0] e;
		rx_buffer_full_irq_enable = 1'b1;
		autobaud_enable = 1'b1;
		for (int i = 0; i < 5; i++) begin
			e = {i < 4, i == 4, 1'b0};
			autobaud_pattern_select = 2'(i % 4);
			repeat (2) @(negedge clk);
			tx.send(d[i % 4], 8, (i < 4) ? 24 : 8, 1'b1, 1'b0);
			chk({autobaud_done_flag, autobaud_error_flag, rx_buffer_full_flag}, e);
			if (i < 4)
				chk(baud_divider > 16'h0016 && baud_divider < 16'h001a, 1'b1);
			chk(irq, i < 4);
			pulse(autobaud_done_clear);
			chk({autobaud_done_flag, autobaud_error_flag}, 2'b00);
		end
		autobaud_enable = 1'b0;
	endtask

	initial begin
		{reset_n, oversample_select, word_length_select, parity_enable, parity_odd,
			multi_buffer, rx_buffer_full_irq_enable, idle_irq_enable, error_irq_enable,
			status_read, data_read, full_flag_clear, idle_clear, baud_divider_wr,
			baud_divider_wdata, autobaud_enable, autobaud_pattern_select,
			autobaud_done_clear, dma_ready} = '0;
		// The receiver stays enabled through every frame, and 8x is used in plain mode only.
		{port_enable, receiver_enable} = 2'b11;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		t_basic();
		t_len();
		t_parity();
		t_errors();
		t_multi();
		t_auto();
		end_of_test();
	end

	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule

//--- rtl/uarb_fifo.sv
// Small synchronous FIFO between the receive buffer register and the DMA side.
`timescale 1ns/100ps
module uarb_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wptr_r;
	logic [PW-1:0]    rptr_r;
	logic [PW:0]      count_r;
	logic             push;
	logic             pop;

	assign in_ready  = (count_r != DEPTH[PW:0]);
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rptr_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wptr_r  <= '0;
			rptr_r  <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= (wptr_r == PW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= (rptr_r == PW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
			end
			count_r <= count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		end
	end
endmodule

//--- rtl/uarb_pkg.sv
// Constants and types shared by the autobaud serial receiver.
package uarb_pkg;
	localparam logic [1:0]  UARB_WL_8       = 2'b00;
	localparam logic [1:0]  UARB_WL_9       = 2'b01;
	localparam logic [1:0]  UARB_WL_7       = 2'b10;
	localparam logic [3:0]  UARB_BITS_8     = 4'h8;
	localparam logic [3:0]  UARB_BITS_9     = 4'h9;
	localparam logic [3:0]  UARB_BITS_7     = 4'h7;
	localparam logic [3:0]  UARB_LAST_16    = 4'hf;
	localparam logic [3:0]  UARB_LAST_8     = 4'h7;
	localparam logic [3:0]  UARB_MID_16     = 4'h8;
	localparam logic [3:0]  UARB_MID_8      = 4'h4;
	localparam logic [4:0]  UARB_ACC_16     = 5'h10;
	localparam logic [4:0]  UARB_ACC_8      = 5'h08;
	localparam logic [15:0] UARB_DIV_RESET  = 16'h0010;
	localparam logic [15:0] UARB_DIV_MIN    = 16'h0010;
	localparam logic [1:0]  UARB_ABD_START  = 2'b00;
	localparam logic [1:0]  UARB_ABD_TWO    = 2'b01;
	localparam logic [1:0]  UARB_ABD_7F     = 2'b10;
	localparam logic [1:0]  UARB_ABD_55     = 2'b11;
	localparam logic [2:0]  UARB_FALLS_7F   = 3'h1;
	localparam logic [2:0]  UARB_FALLS_55   = 3'h4;
	localparam logic [19:0] UARB_ABD_CNTMAX = 20'hfffff;
	localparam int          UARB_DATA_W     = 9;
	localparam int          UARB_FIFO_DEPTH = 4;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uarb_rx_state_e;
	typedef enum logic [1:0] {ABD_IDLE, ABD_ARMED, ABD_MEAS} uarb_abd_state_e;
endpackage

//--- rtl/uarb_rx.sv
// Asynchronous serial receiver with fractional baud divider and autobaud.
// How it works
// [RQ1] Shift LSB first, then move to buffer.
// [RQ2] Sample at 8x or 16x per select.
// [RQ3] Transfer into buffer sets full flag.
// [RQ4] Full flag with enable raises interrupt.
// [RQ5] Single mode: read or zero write clears.
// [RQ6] Multi mode: DMA take clears full flag.
// [RQ7] Software keeps receiver enabled mid-character.
// [RQ8] Break frame reports a framing error.
// [RQ9] Idle frame flagged, interrupt when enabled.
// [RQ10] Completion while full: overrun, keep buffer.
// [RQ11] Overrun interrupts with either enable set.
// [RQ12] Status read then data read clears.
// [RQ13] Noise flagged alongside full flag rising.
// [RQ14] Bad stop bit: framing error, data kept.
// [RQ15] Noise/framing interrupt only in multi mode.
// [RQ16] Software avoids 8x in special modes.
// [RQ17] Divider: 12-bit integer, 4-bit fraction.
// [RQ18] Bit rate is clock over divider.
// [RQ19] Software presets divider, pattern, stays enabled.
// [RQ20] Four autobaud pattern modes supported.
// [RQ21] Autobaud loads divider, sets done, interrupts.
// [RQ22] Bad measurement sets autobaud error flag.
// [RQ23] Clearing done flag restarts autobaud.
// [RQ24] Word length code frames 8/9/7 bits.
// [RQ25] Failed parity check sets parity flag.
// [RQ26] Three-sample majority, disagreement means noise.
`timescale 1ns/100ps
module uarb_rx
	import uarb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        rx_in,
	input  wire logic        port_enable,
	input  wire logic        receiver_enable,
	input  wire logic        oversample_select,
	input  wire logic [1:0]  word_length_select,
	input  wire logic        parity_enable,
	input  wire logic        parity_odd,
	input  wire logic        multi_buffer,
	input  wire logic        rx_buffer_full_irq_enable,
	input  wire logic        idle_irq_enable,
	input  wire logic        error_irq_enable,
	input  wire logic        status_read,
	input  wire logic        data_read,
	input  wire logic        full_flag_clear,
	input  wire logic        idle_clear,
	input  wire logic        baud_divider_wr,
	input  wire logic [15:0] baud_divider_wdata,
	input  wire logic        autobaud_enable,
	input  wire logic [1:0]  autobaud_pattern_select,
	input  wire logic        autobaud_done_clear,
	input  wire logic        dma_ready,
	output logic             dma_valid,
	output logic [8:0]       dma_data,
	output logic [8:0]       rx_data,
	output logic             rx_buffer_full_flag,
	output logic             overrun_flag,
	output logic             noise_flag,
	output logic             framing_error_flag,
	output logic             parity_error_flag,
	output logic             idle_flag,
	output logic             autobaud_done_flag,
	output logic             autobaud_error_flag,
	output logic [15:0]      baud_divider,
	output logic             irq
);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	uarb_rx_state_e  rx_state_r;
	uarb_abd_state_e abd_state_r;
	logic            rx_prev_r;
	logic [16:0]     acc_r;
	logic [3:0]      ph_r;
	logic [3:0]      bn_r;
	logic [8:0]      shf_r;
	logic            s0_r;
	logic            s1_r;
	logic            noise_r;
	logic            par_r;
	logic [8:0]      rx_buf_r;
	logic            full_r;
	logic            ovr_r;
	logic            nf_r;
	logic            fe_r;
	logic            pe_r;
	logic            idle_r;
	logic            idle_armed_r;
	logic [7:0]      idle_ct_r;
	logic            sts_seen_r;
	logic [15:0]     div_r;
	logic [19:0]     abd_cnt_r;
	logic [2:0]      abd_falls_r;
	logic            abd_done_r;
	logic            abd_err_r;
	logic            irq_r;

	logic            active;
	logic            fall;
	logic            rise;
	logic [4:0]      acc_add;
	logic [16:0]     acc_sum;
	logic [16:0]     div_eff;
	logic            tick;
	logic [3:0]      last;
	logic [3:0]      mid;
	logic            decide;
	logic            maj;
	logic            disagree;
	logic [3:0]      nbits;
	logic [8:0]      frm_data;
	logic            complete;
	logic            par_err;
	logic            rd_clr;
	logic            dma_take;
	logic            load;
	logic            err_clr;
	logic [15:0]     frame_prod;
	logic [7:0]      frame_ticks;
	logic            abd_hold;
	logic            abd_finish;
	logic [19:0]     abd_len;
	logic [19:0]     abd_res;
	logic            abd_bad;
	logic            fifo_in_ready;

	assign active = port_enable & receiver_enable;
	assign fall   = rx_prev_r & ~rx_in;
	assign rise   = ~rx_prev_r & rx_in;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_prev_r <= 1'b1;
		end else begin
			rx_prev_r <= rx_in;
		end
	end

	// ---------------------------------------------------------------
	// Oversampling tick from the fractional divider
	// ---------------------------------------------------------------
	// The accumulator adds the oversampling factor each clock and wraps at
	// the raw divider, so a bit lasts exactly divider clocks at either rate
	// and the fraction is spread evenly rather than lumped at a bit's end.
	always_comb begin
		acc_add = oversample_select ? UARB_ACC_8 : UARB_ACC_16; // [RQ2]
		acc_sum = acc_r + {12'h000, acc_add};
		if (div_r < {11'h000, acc_add}) begin
			div_eff = {12'h000, acc_add};
		end else begin
			div_eff = {1'b0, div_r}; // [RQ17] [RQ18]
		end
		tick = (acc_sum >= div_eff);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_r <= '0;
		end else if (!active || (rx_state_r == RX_IDLE && fall)) begin
			acc_r <= '0;
		end else if (tick) begin
			acc_r <= acc_sum - div_eff;
		end else begin
			acc_r <= acc_sum;
		end
	end

	// ---------------------------------------------------------------
	// Frame decoding
	// ---------------------------------------------------------------
	always_comb begin
		last     = oversample_select ? UARB_LAST_8 : UARB_LAST_16;
		mid      = oversample_select ? UARB_MID_8 : UARB_MID_16;
		decide   = tick && (ph_r == mid + 4'h1) && (rx_state_r != RX_IDLE);
		maj      = (s0_r & s1_r) | (s0_r & rx_in) | (s1_r & rx_in); // [RQ26]
		disagree = !((s0_r == s1_r) && (s1_r == rx_in)); // [RQ26]
		unique case (word_length_select) // [RQ24]
			UARB_WL_9: nbits = UARB_BITS_9;
			UARB_WL_7: nbits = UARB_BITS_7;
			default:   nbits = UARB_BITS_8;
		endcase
	end

	// Word length alone decides where the character sits in the shifter; with parity on,
	// the parity bit itself is stripped so software sees only data.
	always_comb begin
		unique case (word_length_select) // [RQ24]
			UARB_WL_9: frm_data = shf_r;
			UARB_WL_7: frm_data = {2'b00, shf_r[8:2]};
			default:   frm_data = {1'b0, shf_r[8:1]};
		endcase
		if (parity_enable) begin
			frm_data[nbits - 4'h1] = 1'b0;
		end
	end

	assign complete = decide && (rx_state_r == RX_STOP);
	assign par_err  = parity_enable & (par_r ^ parity_odd); // [RQ25]

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_state_r <= RX_IDLE;
			ph_r       <= '0;
			bn_r       <= '0;
			shf_r      <= '0;
			s0_r       <= 1'b1;
			s1_r       <= 1'b1;
			noise_r    <= 1'b0;
			par_r      <= 1'b0;
		end else if (!active || abd_hold) begin
			rx_state_r <= RX_IDLE; // [RQ7]
		end else begin
			unique case (rx_state_r)
				RX_IDLE: begin
					if (fall) begin
						rx_state_r <= RX_START;
						ph_r       <= '0;
						bn_r       <= '0;
						noise_r    <= 1'b0;
						par_r      <= 1'b0;
					end
				end
				RX_START, RX_DATA, RX_STOP: begin
					if (tick) begin
						ph_r <= (ph_r == last) ? 4'h0 : ph_r + 4'h1;
						if (ph_r == mid - 4'h1) begin
							s0_r <= rx_in;
						end
						if (ph_r == mid) begin
							s1_r <= rx_in;
						end
					end
					if (decide) begin
						noise_r <= noise_r | disagree;
						unique case (rx_state_r)
							RX_START: begin
								// A start that reads high was a glitch, not a frame.
								rx_state_r <= maj ? RX_IDLE : RX_DATA;
							end
							RX_DATA: begin
								shf_r <= {maj, shf_r[8:1]}; // [RQ1]
								par_r <= par_r ^ maj;
								bn_r  <= bn_r + 4'h1;
								if (bn_r == nbits - 4'h1) begin
									rx_state_r <= RX_STOP;
								end
							end
							default: begin
								rx_state_r <= RX_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Receive buffer register and status flags
	// ---------------------------------------------------------------
	assign dma_take = multi_buffer & full_r & fifo_in_ready; // [RQ6]
	assign rd_clr   = multi_buffer ? dma_take : (data_read | full_flag_clear); // [RQ5]
	assign load     = complete & (~full_r | rd_clr);
	assign err_clr  = data_read & sts_seen_r; // [RQ12]

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_buf_r <= '0;
			full_r   <= 1'b0;
		end else begin
			if (load) begin
				rx_buf_r <= frm_data; // [RQ1] [RQ13] [RQ14]
			end
			if (load) begin
				full_r <= 1'b1; // [RQ3] [RQ6]
			end else if (rd_clr) begin
				full_r <= 1'b0; // [RQ5] [RQ6]
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sts_seen_r <= 1'b0;
		end else if (status_read) begin
			sts_seen_r <= 1'b1;
		end else if (data_read) begin
			sts_seen_r <= 1'b0;
		end
	end

	// Error flags: a new error in the clearing cycle survives the clear.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ovr_r <= 1'b0;
			nf_r  <= 1'b0;
			fe_r  <= 1'b0;
			pe_r  <= 1'b0;
		end else begin
			if (complete && !load) begin
				ovr_r <= 1'b1; // [RQ10]
			end else if (err_clr) begin
				ovr_r <= 1'b0; // [RQ12]
			end
			if (load && (noise_r || disagree)) begin
				nf_r <= 1'b1; // [RQ13]
			end else if (err_clr) begin
				nf_r <= 1'b0;
			end
			if (load && !maj) begin
				fe_r <= 1'b1; // [RQ8] [RQ14]
			end else if (err_clr) begin
				fe_r <= 1'b0;
			end
			if (load && par_err) begin
				pe_r <= 1'b1; // [RQ25]
			end else if (err_clr) begin
				pe_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Idle frame detection
	// ---------------------------------------------------------------
	// An idle frame has no start edge, so it is seen as a whole frame time of
	// high line after a received character.
	assign frame_prod  = ({12'h000, nbits} + 16'h0002) * ({12'h000, last} + 16'h0001);
	assign frame_ticks = frame_prod[7:0];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_ct_r    <= '0;
			idle_armed_r <= 1'b0;
			idle_r       <= 1'b0;
		end else begin
			if (!active || rx_state_r != RX_IDLE || !rx_in) begin
				idle_ct_r <= '0;
			end else if (tick && idle_armed_r) begin
				idle_ct_r <= idle_ct_r + 8'h01;
			end
			if (complete) begin
				idle_armed_r <= 1'b1;
			end else if (idle_armed_r && tick && idle_ct_r == frame_ticks - 8'h01) begin
				idle_armed_r <= 1'b0;
			end
			if (idle_armed_r && tick && idle_ct_r == frame_ticks - 8'h01) begin
				idle_r <= 1'b1; // [RQ9]
			end else if (idle_clear) begin
				idle_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Automatic baud rate detection
	// ---------------------------------------------------------------
	// While a measurement is pending the frame decoder is held idle, so the
	// measured character itself is not delivered to the buffer.
	assign abd_hold = port_enable & autobaud_enable & ~abd_done_r & ~abd_err_r;
	assign abd_len  = abd_cnt_r + 20'h00001;

	always_comb begin
		abd_finish = 1'b0;
		if (abd_state_r == ABD_MEAS) begin
			unique case (autobaud_pattern_select) // [RQ20]
				UARB_ABD_START, UARB_ABD_TWO: abd_finish = rise;
				UARB_ABD_7F: abd_finish = fall && (abd_falls_r + 3'h1 == UARB_FALLS_7F);
				default: abd_finish = fall && (abd_falls_r + 3'h1 == UARB_FALLS_55);
			endcase
		end
		unique case (autobaud_pattern_select)
			UARB_ABD_START: abd_res = abd_len;
			UARB_ABD_TWO:   abd_res = {1'b0, abd_len[19:1]};
			default:        abd_res = {3'b000, abd_len[19:3]};
		endcase
		abd_bad = (abd_res[19:16] != 4'h0) || (abd_res[15:0] < UARB_DIV_MIN); // [RQ22]
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			abd_state_r <= ABD_IDLE;
			abd_cnt_r   <= '0;
			abd_falls_r <= '0;
		end else if (!abd_hold) begin
			abd_state_r <= ABD_IDLE;
		end else begin
			unique case (abd_state_r)
				ABD_IDLE: begin
					abd_state_r <= ABD_ARMED;
				end
				ABD_ARMED: begin
					if (fall) begin
						abd_state_r <= ABD_MEAS;
						abd_cnt_r   <= '0;
						abd_falls_r <= '0;
					end
				end
				ABD_MEAS: begin
					if (abd_cnt_r != UARB_ABD_CNTMAX) begin
						abd_cnt_r <= abd_cnt_r + 20'h00001;
					end
					if (fall) begin
						abd_falls_r <= abd_falls_r + 3'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			abd_done_r <= 1'b0;
			abd_err_r  <= 1'b0;
		end else begin
			if (abd_finish && !abd_bad) begin
				abd_done_r <= 1'b1; // [RQ21]
			end else if (autobaud_done_clear) begin
				abd_done_r <= 1'b0; // [RQ23]
			end
			if (abd_hold && ((abd_finish && abd_bad) ||
				(abd_state_r == ABD_MEAS && abd_cnt_r == UARB_ABD_CNTMAX))) begin
				abd_err_r <= 1'b1; // [RQ22]
			end else if (autobaud_done_clear) begin
				abd_err_r <= 1'b0; // [RQ23]
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_r <= UARB_DIV_RESET;
		end else if (abd_finish && !abd_bad) begin
			div_r <= abd_res[15:0]; // [RQ21]
		end else if (baud_divider_wr) begin
			div_r <= baud_divider_wdata; // [RQ17]
		end
	end

	// ---------------------------------------------------------------
	// Interrupt and DMA queue
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (full_r & rx_buffer_full_irq_enable) | // [RQ4]
				(ovr_r & (rx_buffer_full_irq_enable | error_irq_enable)) | // [RQ11]
				(idle_r & idle_irq_enable) | // [RQ9]
				(multi_buffer & error_irq_enable & (nf_r | fe_r)) | // [RQ15]
				(abd_done_r & rx_buffer_full_irq_enable); // [RQ21]
		end
	end

	uarb_fifo #(
		.WIDTH (UARB_DATA_W),
		.DEPTH (UARB_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (multi_buffer & full_r),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_buf_r),
		.out_valid (dma_valid),
		.out_ready (dma_ready),
		.out_data  (dma_data)
	);

	assign rx_data             = rx_buf_r;
	assign rx_buffer_full_flag = full_r;
	assign overrun_flag        = ovr_r;
	assign noise_flag          = nf_r;
	assign framing_error_flag  = fe_r;
	assign parity_error_flag   = pe_r;
	assign idle_flag           = idle_r;
	assign autobaud_done_flag  = abd_done_r;
	assign autobaud_error_flag = abd_err_r;
	assign baud_divider        = div_r;
	assign irq                 = irq_r;
endmodule
